// [rfcrc_top.sv]
// Purpose: Tx/rx CRC and tx framing
// Assumes: One clock, sync active-high reset, LSB first
// Notes:   8-bit register port, read data one cycle later
`include "rfcrc_cfg.svh"

module rfcrc_top #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_rst,
    // Register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [7:0]        o_rdata,
    output logic                   o_irq,
    // Nonvolatile user presets
    input  wire logic [15:0]       i_user_preset16,
    input  wire logic [7:0]        i_user_preset8,
    input  wire logic [4:0]        i_user_preset5,
    // Modulation
    input  wire logic              i_internal_tx_envelope,
    input  wire logic              i_external_signal_input,
    output logic                   o_mod,
    // Tx byte stream from FIFO
    input  wire logic [7:0]        i_tx_data,
    input  wire logic              i_tx_valid,
    input  wire logic              i_tx_last,
    output logic                   o_tx_ready,
    // Tx bit stream to encoder
    input  wire logic              i_etu_tick,
    input  wire logic              i_tx_bit_ready,
    output logic                   o_tx_bit,
    output logic                   o_tx_bit_valid,
    output logic                   o_tx_symbol,
    // Rx bit stream from decoder
    input  wire logic              i_rx_start,
    input  wire logic              i_rx_bit,
    input  wire logic              i_rx_bit_valid,
    input  wire logic              i_rx_bit_is_crc,
    input  wire logic              i_rx_end,
    // Rx bytes to FIFO
    output logic      [7:0]        o_rx_byte,
    output logic                   o_rx_byte_valid
);
    initial begin
        if (ADDR_W < 7) begin
            $error("ADDR_W too small");
        end
    end

    rfcrc_pkg::rfcrc_state_t st_r;
    rfcrc_pkg::rfcrc_state_t st_nxt;

    function automatic logic [15:0] crc_mask(input logic [1:0] kind);
        case (kind)
            `RFCRC_KIND_C5:  crc_mask = `RFCRC_MASK5;
            `RFCRC_KIND_C8:  crc_mask = `RFCRC_MASK8;
            `RFCRC_KIND_C16: crc_mask = `RFCRC_MASK16;
            default:         crc_mask = `RFCRC_ZERO16;
        endcase
    endfunction

    function automatic logic [4:0] crc_width(input logic [1:0] kind);
        case (kind)
            `RFCRC_KIND_C5:  crc_width = `RFCRC_W5;
            `RFCRC_KIND_C8:  crc_width = `RFCRC_W8;
            default:         crc_width = `RFCRC_W16;
        endcase
    endfunction

    // Reflected step; narrow kinds stay in their width
    function automatic logic [15:0] crc_step(input logic [1:0] kind, input logic [15:0] c,
                                             input logic b);
        logic [15:0] poly;
        poly = `RFCRC_POLY16;
        case (kind)
            `RFCRC_KIND_C5: poly = `RFCRC_POLY5;
            `RFCRC_KIND_C8: poly = `RFCRC_POLY8;
            default:        poly = `RFCRC_POLY16;
        endcase
        crc_step = (c >> 1) ^ ((c[0] ^ b) ? poly : `RFCRC_ZERO16);
    endfunction

    // Returns {usable, start}; unusable means no CRC
    function automatic logic [16:0] crc_preset(input logic [1:0] kind, input logic [2:0] code,
                                               input logic [15:0] u16, input logic [7:0] u8,
                                               input logic [4:0] u5);
        logic [15:0] v;
        logic        ok;
        v  = `RFCRC_ZERO16;
        ok = 1'b1;
        case (code)
            `RFCRC_PC_0: v = `RFCRC_ZERO16;
            `RFCRC_PC_1: v = (kind == `RFCRC_KIND_C16) ? `RFCRC_P16_1 :
                             (kind == `RFCRC_KIND_C8) ? `RFCRC_P8_1 : `RFCRC_P5_1;
            `RFCRC_PC_2: begin
                v  = (kind == `RFCRC_KIND_C16) ? `RFCRC_P16_2 : `RFCRC_P8_2;
                ok = (kind != `RFCRC_KIND_C5);
            end
            `RFCRC_PC_3: begin
                v  = (kind == `RFCRC_KIND_C16) ? `RFCRC_P16_3 : `RFCRC_P8_3;
                ok = (kind != `RFCRC_KIND_C5);
            end
            `RFCRC_PC_USER: v = (kind == `RFCRC_KIND_C16) ? u16 :
                                (kind == `RFCRC_KIND_C8) ? {8'h00, u8} : {11'h000, u5};
            `RFCRC_PC_ONES: v = `RFCRC_MASK16;
            default: ok = 1'b0;
        endcase
        if (crc_mask(kind) == `RFCRC_ZERO16) begin
            ok = 1'b0;
        end
        crc_preset = {ok, v & crc_mask(kind)};
    endfunction

    // Config field views
    logic [1:0]  tx_crc_kind;
    logic [2:0]  tx_crc_start_code;
    logic [1:0]  rx_crc_kind;
    logic [2:0]  rx_crc_start_code;
    logic [2:0]  final_byte_bitcount;
    logic [1:0]  mod_source_sel;
    logic [16:0] tx_pre;
    logic [16:0] rx_pre;
    logic        tx_take;
    logic        tx_shift;
    logic        rx_crc_fwd;
    logic        rx_to_asm;

    assign tx_crc_kind         = st_r.tx_crc[`RFCRC_F_KIND_HI:`RFCRC_F_KIND_LO];
    assign tx_crc_start_code   = st_r.tx_crc[`RFCRC_F_PRE_HI:`RFCRC_F_PRE_LO];
    assign rx_crc_kind         = st_r.rx_crc[`RFCRC_F_KIND_HI:`RFCRC_F_KIND_LO];
    assign rx_crc_start_code   = st_r.rx_crc[`RFCRC_F_PRE_HI:`RFCRC_F_PRE_LO];
    assign final_byte_bitcount = st_r.tx_framing[`RFCRC_F_LAST_HI:`RFCRC_F_LAST_LO];
    assign mod_source_sel      = st_r.tx_control[`RFCRC_F_MOD_HI:`RFCRC_F_MOD_LO];
    assign tx_pre = crc_preset(tx_crc_kind, tx_crc_start_code, i_user_preset16,
                               i_user_preset8, i_user_preset5);
    assign rx_pre = crc_preset(rx_crc_kind, rx_crc_start_code, i_user_preset16,
                               i_user_preset8, i_user_preset5);

    // Ready and irq are combinational; valids and data outputs are flops
    assign o_tx_ready     = (st_r.txst == rfcrc_pkg::TX_DATA) && !st_r.tx_have && !st_r.tx_lastb;
    assign tx_take        = o_tx_ready && i_tx_valid;
    assign o_tx_bit_valid = st_r.tx_have;
    assign tx_shift       = st_r.tx_have && i_tx_bit_ready;
    assign o_tx_bit       = st_r.tx_sh[0];
    assign o_tx_symbol    = st_r.tx_sym;
    assign o_mod          = st_r.mod;
    assign o_rdata        = st_r.rdata;
    assign o_rx_byte      = st_r.rx_byte;
    assign o_rx_byte_valid = st_r.rx_byte_vld;
    assign o_irq          = |(st_r.irq_status & st_r.irq_mask);

    // Forwarding serves unaligned CRCs; check runs either way
    assign rx_crc_fwd = st_r.rx_crc[`RFCRC_F_TO_FIFO];
    assign rx_to_asm  = i_rx_bit_valid && (!i_rx_bit_is_crc || rx_crc_fwd);

    always_comb begin
        logic [2:0]  ev;
        logic [15:0] rx_exp;
        logic        wr_hit_status;
        ev            = 3'h0;
        rx_exp        = `RFCRC_ZERO16;
        wr_hit_status = 1'b0;
        st_nxt        = st_r;
        st_nxt.tx_sym      = 1'b0;
        st_nxt.rx_byte_vld = 1'b0;

        // Register writes
        if (i_wr && (i_addr[ADDR_W-1:7] == '0)) begin
            case (i_addr[6:0])
                `RFCRC_OFS_TX_CONTROL: st_nxt.tx_control = i_wdata;
                `RFCRC_OFS_TX_TRIM:    st_nxt.tx_trim    = i_wdata;
                `RFCRC_OFS_TX_CRC:     st_nxt.tx_crc     = {1'b0, i_wdata[6:0]};
                `RFCRC_OFS_RX_CRC:     st_nxt.rx_crc     = i_wdata;
                `RFCRC_OFS_TX_FRAMING: st_nxt.tx_framing = {3'h0, i_wdata[4:0]};
                `RFCRC_OFS_IRQ_STATUS: wr_hit_status     = 1'b1;
                `RFCRC_OFS_IRQ_MASK:   st_nxt.irq_mask   = i_wdata[`RFCRC_IRQ_BITS-1:0];
                default: ;
            endcase
        end

        // Reads answer next cycle; unmapped give zero
        st_nxt.rdata = 8'h00;
        if (i_rd && (i_addr[ADDR_W-1:7] == '0)) begin
            case (i_addr[6:0])
                `RFCRC_OFS_TX_CONTROL: st_nxt.rdata = st_r.tx_control;
                `RFCRC_OFS_TX_TRIM:    st_nxt.rdata = st_r.tx_trim;
                `RFCRC_OFS_TX_CRC:     st_nxt.rdata = st_r.tx_crc;
                `RFCRC_OFS_RX_CRC:     st_nxt.rdata = st_r.rx_crc;
                `RFCRC_OFS_TX_FRAMING: st_nxt.rdata = st_r.tx_framing;
                `RFCRC_OFS_IRQ_STATUS: st_nxt.rdata = {5'h00, st_r.irq_status};
                `RFCRC_OFS_IRQ_MASK:   st_nxt.rdata = {5'h00, st_r.irq_mask};
                `RFCRC_OFS_TX_CMD:     st_nxt.rdata = {6'h00, st_r.txst != rfcrc_pkg::TX_IDLE,
                                                       1'b0};
                default:               st_nxt.rdata = 8'h00;
            endcase
        end

        // Mod source registered for a glitch-free pin
        case (mod_source_sel)
            `RFCRC_MOD_ENV: st_nxt.mod = i_internal_tx_envelope;
            `RFCRC_MOD_EXT: st_nxt.mod = i_external_signal_input;
            default:        st_nxt.mod = 1'b0;
        endcase

        // Transmit sequencer
        case (st_r.txst)
            rfcrc_pkg::TX_IDLE: begin
                if (i_wr && (i_addr == ADDR_W'(`RFCRC_OFS_TX_CMD)) && i_wdata[`RFCRC_F_CMD_START]) begin
                    st_nxt.tx_crcv  = tx_pre[15:0];
                    st_nxt.tx_lastb = 1'b0;
                    st_nxt.txst     = rfcrc_pkg::TX_GRID;
                end
            end
            rfcrc_pkg::TX_GRID: begin
                // Unaligned, a start may fall inside a unit
                if (i_etu_tick || !st_r.tx_framing[`RFCRC_F_GRID]) begin
                    if (st_r.tx_framing[`RFCRC_F_PAYLOAD]) begin
                        st_nxt.txst = rfcrc_pkg::TX_DATA;
                    end else begin
                        st_nxt.tx_sym = 1'b1;
                        st_nxt.txst   = rfcrc_pkg::TX_SYM;
                    end
                end
            end
            rfcrc_pkg::TX_SYM: begin
                st_nxt.txst = rfcrc_pkg::TX_IDLE;
                ev[`RFCRC_IRQ_TX_DONE] = 1'b1;
            end
            rfcrc_pkg::TX_DATA: begin
                if (tx_take) begin
                    st_nxt.tx_sh    = {8'h00, i_tx_data};
                    st_nxt.tx_have  = 1'b1;
                    st_nxt.tx_lastb = i_tx_last;
                    st_nxt.tx_cnt   = (i_tx_last && (final_byte_bitcount != 3'h0)) ?
                                      {2'b00, final_byte_bitcount} : {1'b0, `RFCRC_BYTE_BITS};
                end else if (tx_shift) begin
                    st_nxt.tx_sh   = st_r.tx_sh >> 1;
                    st_nxt.tx_crcv = crc_step(tx_crc_kind, st_r.tx_crcv, st_r.tx_sh[0]);
                    st_nxt.tx_cnt  = st_r.tx_cnt - 5'h01;
                    if (st_r.tx_cnt == 5'h01) begin
                        st_nxt.tx_have = 1'b0;
                        if (st_r.tx_lastb) begin
                            st_nxt.tx_lastb = 1'b0;
                            st_nxt.txst     = rfcrc_pkg::TX_CRC;
                        end
                    end
                end
            end
            rfcrc_pkg::TX_CRC: begin
                if (!st_r.tx_have) begin
                    if (st_r.tx_crc[`RFCRC_F_EN] && tx_pre[16] && !st_r.tx_lastb) begin
                        st_nxt.tx_sh   = st_r.tx_crc[`RFCRC_F_INV] ?
                                         (st_r.tx_crcv ^ crc_mask(tx_crc_kind)) :
                                         st_r.tx_crcv;
                        st_nxt.tx_cnt  = crc_width(tx_crc_kind);
                        st_nxt.tx_have = 1'b1;
                        st_nxt.tx_lastb = 1'b1;
                    end else begin
                        st_nxt.tx_lastb = 1'b0;
                        st_nxt.txst     = rfcrc_pkg::TX_IDLE;
                        ev[`RFCRC_IRQ_TX_DONE] = 1'b1;
                    end
                end else if (tx_shift) begin
                    st_nxt.tx_sh  = st_r.tx_sh >> 1;
                    st_nxt.tx_cnt = st_r.tx_cnt - 5'h01;
                    if (st_r.tx_cnt == 5'h01) begin
                        st_nxt.tx_have  = 1'b0;
                        st_nxt.tx_lastb = 1'b0;
                        st_nxt.txst     = rfcrc_pkg::TX_IDLE;
                        ev[`RFCRC_IRQ_TX_DONE] = 1'b1;
                    end
                end
            end
            default: st_nxt.txst = rfcrc_pkg::TX_IDLE;
        endcase

        // Rx: CRC over data bits, CRC bits stored LSB first
        if (i_rx_start) begin
            st_nxt.rx_crcv = rx_pre[15:0];
            st_nxt.rx_recv = `RFCRC_ZERO16;
            st_nxt.rx_ridx = 5'h00;
            st_nxt.rx_cnt  = 4'h0;
            st_nxt.rx_sh   = 8'h00;
        end else if (i_rx_bit_valid) begin
            if (i_rx_bit_is_crc) begin
                st_nxt.rx_recv[st_r.rx_ridx[3:0]] = i_rx_bit;
                st_nxt.rx_ridx = st_r.rx_ridx + 5'h01;
            end else begin
                st_nxt.rx_crcv = crc_step(rx_crc_kind, st_r.rx_crcv, i_rx_bit);
            end
            if (rx_to_asm) begin
                st_nxt.rx_sh  = {i_rx_bit, st_r.rx_sh[7:1]};
                st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
                if (st_r.rx_cnt == (`RFCRC_BYTE_BITS - 4'h1)) begin
                    st_nxt.rx_byte     = {i_rx_bit, st_r.rx_sh[7:1]};
                    st_nxt.rx_byte_vld = 1'b1;
                    st_nxt.rx_cnt      = 4'h0;
                end
            end
        end else if (i_rx_end) begin
            // Flush a partial byte, right-aligned
            if (st_r.rx_cnt != 4'h0) begin
                st_nxt.rx_byte     = st_r.rx_sh >> (`RFCRC_BYTE_BITS - st_r.rx_cnt);
                st_nxt.rx_byte_vld = 1'b1;
                st_nxt.rx_cnt      = 4'h0;
            end
            rx_exp = st_r.rx_crc[`RFCRC_F_INV] ?
                     (st_r.rx_crcv ^ crc_mask(rx_crc_kind)) : st_r.rx_crcv;
            ev[`RFCRC_IRQ_RX_DONE] = 1'b1;
            if (st_r.rx_crc[`RFCRC_F_EN] && rx_pre[16] &&
                (rx_exp != (st_r.rx_recv & crc_mask(rx_crc_kind)))) begin
                ev[`RFCRC_IRQ_CRC_ERR] = 1'b1;
            end
        end

        // Sticky status: write one clears, a same-cycle event wins
        st_nxt.irq_status = (st_r.irq_status &
                             ~(wr_hit_status ? i_wdata[`RFCRC_IRQ_BITS-1:0] : 3'h0)) | ev;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st_r            <= '0;
            st_r.tx_control <= `RFCRC_RST_REG;
            st_r.tx_trim    <= `RFCRC_RST_REG;
            st_r.tx_crc     <= `RFCRC_RST_REG;
            st_r.rx_crc     <= `RFCRC_RST_REG;
            st_r.tx_framing <= `RFCRC_RST_REG;
            st_r.txst       <= rfcrc_pkg::TX_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // rfcrc_top

// [rfcrc_cfg.svh]
// Purpose: Numbers of the frame CRC block
// Assumes: 8-bit register port, byte addresses as printed
// Notes:   Definitions only
`ifndef RFCRC_CFG_SVH
`define RFCRC_CFG_SVH
// Register offsets
`define RFCRC_OFS_TX_CONTROL   8'h2a
`define RFCRC_OFS_TX_TRIM      8'h2b
`define RFCRC_OFS_TX_CRC       8'h2c
`define RFCRC_OFS_RX_CRC       8'h2d
`define RFCRC_OFS_TX_FRAMING   8'h2e
`define RFCRC_OFS_IRQ_STATUS   8'h40
`define RFCRC_OFS_IRQ_MASK     8'h41
`define RFCRC_OFS_TX_CMD       8'h42
// Reset values
`define RFCRC_RST_REG          8'h00
// CRC config fields, tx and rx; RFCRC_F_TO_FIFO rx only
`define RFCRC_F_EN             0
`define RFCRC_F_INV            1
`define RFCRC_F_KIND_LO        2
`define RFCRC_F_KIND_HI        3
`define RFCRC_F_PRE_LO         4
`define RFCRC_F_PRE_HI         6
`define RFCRC_F_TO_FIFO        7
// Framing fields
`define RFCRC_F_LAST_LO        0
`define RFCRC_F_LAST_HI        2
`define RFCRC_F_PAYLOAD        3
`define RFCRC_F_GRID           4
// Modulation source field
`define RFCRC_F_MOD_LO         0
`define RFCRC_F_MOD_HI         1
// Interrupt status bits
`define RFCRC_IRQ_TX_DONE      0
`define RFCRC_IRQ_RX_DONE      1
`define RFCRC_IRQ_CRC_ERR      2
`define RFCRC_IRQ_BITS         3
// Command / status bits
`define RFCRC_F_CMD_START      0
// CRC kind and modulation codes
`define RFCRC_KIND_C5          2'h0
`define RFCRC_KIND_C8          2'h1
`define RFCRC_KIND_C16         2'h2
`define RFCRC_MOD_ENV          2'h1
`define RFCRC_MOD_EXT          2'h2
// Preset codes and values
`define RFCRC_PC_0             3'h0
`define RFCRC_PC_1             3'h1
`define RFCRC_PC_2             3'h2
`define RFCRC_PC_3             3'h3
`define RFCRC_PC_USER          3'h6
`define RFCRC_PC_ONES          3'h7
`define RFCRC_P16_1            16'h6363
`define RFCRC_P16_2            16'ha671
`define RFCRC_P16_3            16'hfffe
`define RFCRC_P8_1             16'h0012
`define RFCRC_P8_2             16'h00bf
`define RFCRC_P8_3             16'h00fd
`define RFCRC_P5_1             16'h0012
`define RFCRC_ZERO16           16'h0000
// Masks and reflected polynomials
`define RFCRC_MASK16           16'hffff
`define RFCRC_MASK8            16'h00ff
`define RFCRC_MASK5            16'h001f
`define RFCRC_POLY16           16'h8408
`define RFCRC_POLY8            16'h00b8
`define RFCRC_POLY5            16'h0014
`define RFCRC_W16              5'h10
`define RFCRC_W8               5'h08
`define RFCRC_W5               5'h05
`define RFCRC_BYTE_BITS        4'h8
`endif

// [rfcrc_pkg.sv]
// Purpose: Types of the frame CRC block
// Assumes: rfcrc_cfg.svh for all numbers
// Notes:   State is a single packed struct
package rfcrc_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_GRID, TX_DATA, TX_CRC, TX_SYM} rfcrc_txst_t;

    typedef struct packed {
        logic [7:0]  tx_control;
        logic [7:0]  tx_trim;
        logic [7:0]  tx_crc;
        logic [7:0]  rx_crc;
        logic [7:0]  tx_framing;
        logic [2:0]  irq_status;
        logic [2:0]  irq_mask;
        logic [7:0]  rdata;
        rfcrc_txst_t txst;
        logic [15:0] tx_sh;
        logic [4:0]  tx_cnt;
        logic        tx_have;
        logic        tx_lastb;
        logic [15:0] tx_crcv;
        logic        tx_sym;
        logic        mod;
        logic [15:0] rx_crcv;
        logic [15:0] rx_recv;
        logic [4:0]  rx_ridx;
        logic [7:0]  rx_sh;
        logic [3:0]  rx_cnt;
        logic [7:0]  rx_byte;
        logic        rx_byte_vld;
    } rfcrc_state_t;
endpackage

// [rfcrc_assertions.sv]
// Purpose: Port checks
// Assumes: One-cycle strobes
// Notes:   Shadows a few registers
module rfcrc_assertions #(parameter int ADDR_W = 8) (
    // Clock, reset, register port
    input wire logic              i_core_clk,
    input wire logic              i_rst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0]        i_wdata,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire logic [7:0]        o_rdata,
    input wire logic              o_irq,
    // Modulation and tx streams
    input wire logic              i_internal_tx_envelope,
    input wire logic              o_mod,
    input wire logic [7:0]        i_tx_data,
    input wire logic              i_tx_valid,
    input wire logic              o_tx_ready,
    input wire logic              i_tx_bit_ready,
    input wire logic              o_tx_bit,
    input wire logic              o_tx_bit_valid,
    input wire logic              o_tx_symbol
);
    logic [1:0] sel_r;
    logic [2:0] msk_r;
    logic [7:0] trim_r;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sel_r  <= 2'h0;
            msk_r  <= 3'h0;
            trim_r <= 8'h00;
        end else if (i_wr) begin
            if (i_addr == ADDR_W'(8'h2a)) sel_r <= i_wdata[1:0];
            if (i_addr == ADDR_W'(8'h41)) msk_r <= i_wdata[2:0];
            if (i_addr == ADDR_W'(8'h2b)) trim_r <= i_wdata;
        end
    end
    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("stray read data");
    AST_RD_TRIM: assert property ($past(i_rd) && $past(i_addr) == ADDR_W'(8'h2b)
        |-> o_rdata == $past(trim_r)) else $error("trim readback");
    AST_MOD_ENV: assert property ($past(sel_r) == 2'h1 |-> o_mod == $past(i_internal_tx_envelope))
        else $error("mod not envelope");
    AST_MOD_OFF: assert property ($past(sel_r) == 2'h0 || $past(sel_r) == 2'h3 |-> !o_mod)
        else $error("mod while off");
    AST_MASK_IRQ: assert property (msk_r == 3'h0 |-> !o_irq) else $error("masked irq");
    AST_HOLD: assert property (o_tx_bit_valid && !i_tx_bit_ready |=> o_tx_bit_valid && $stable(o_tx_bit))
        else $error("bit moved in stall");
    AST_EXCL: assert property (!(o_tx_ready && o_tx_bit_valid)) else $error("ready with bit");
    AST_TAKE: assert property (o_tx_ready && i_tx_valid && !i_tx_data[0] |=> o_tx_bit_valid && !o_tx_bit)
        else $error("first bit not lsb");
    AST_SYM: assert property (o_tx_symbol |=> !o_tx_symbol && !o_tx_bit_valid)
        else $error("bad symbol");
    CV_SYM: cover property (o_tx_symbol);
    CV_TAKE: cover property (o_tx_ready && i_tx_valid);
    CV_IRQ: cover property (o_irq);
endmodule // rfcrc_assertions
bind rfcrc_top rfcrc_assertions #(.ADDR_W(ADDR_W)) rfcrc_assertions_inst (.i_core_clk, .i_rst,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq, .i_internal_tx_envelope, .o_mod, .i_tx_data,
    .i_tx_valid, .o_tx_ready, .i_tx_bit_ready, .o_tx_bit, .o_tx_bit_valid, .o_tx_symbol);

// [rfcrc_partner.sv]
// Purpose: Far-side encoder
// Assumes: Bit moves on valid and ready
// Notes:   Slow mode stalls at random
module rfcrc_partner (
    // Clock and mode
    input  wire logic i_core_clk,
    input  wire logic i_slow,
    // Bit stream
    input  wire logic i_bit,
    input  wire logic i_bit_valid,
    output logic      o_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    bit q[$];
    initial o_ready = 1'b0;
    always @(posedge i_core_clk) begin
        if (i_bit_valid && o_ready) q.push_back(i_bit); // Air order kept as sent
        o_ready <= i_slow ? 1'($urandom_range(1)) : 1'b1;
    end
endmodule // rfcrc_partner

// [rfcrc_top_bench.sv]
// Purpose: Self-checking bench
// Assumes: Two-byte frames fit one 32-bit compare
// Notes:   Expected CRCs computed bit by bit
module rfcrc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_tx_valid = 0, i_tx_last = 0, slow = 0;
    logic i_rx_start = 0, i_rx_bit = 0, i_rx_bit_valid = 0, i_rx_bit_is_crc = 0, i_rx_end = 0;
    logic i_etu_tick = 0, env = 0, ext = 0, tx_bit_ready, o_irq, o_mod, o_tx_ready, o_tx_bit;
    logic o_tx_bit_valid, o_tx_symbol, o_rx_byte_valid;
    logic [7:0] i_addr = 0, i_wdata = 0, i_tx_data = 0, o_rdata, o_rx_byte, rv, feed[$], rxq[$];
    logic [15:0] up16 = 0;
    int err_count = 0, checked = 0, nsym = 0, poly[3] = '{'h14, 'hb8, 'h8408}, wid[3] = '{5, 8, 16};
    int pt[4][8] = '{'{0, 16'h12, -1, -1, -1, -1, 0, 16'h1f}, '{0, 16'h12, 16'hbf, 16'hfd, -1, -1, 0,
        16'hff}, '{0, 16'h6363, 16'ha671, 16'hfffe, -1, -1, 0, 16'hffff}, '{8{-1}}};
    rfcrc_top rfcrc_top_inst (.i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq,
        .i_user_preset16(up16), .i_user_preset8(up16[7:0]), .i_user_preset5(up16[4:0]),
        .i_internal_tx_envelope(env), .i_external_signal_input(ext), .o_mod, .i_tx_data, .i_tx_valid,
        .i_tx_last, .o_tx_ready, .i_etu_tick, .i_tx_bit_ready(tx_bit_ready), .o_tx_bit,
        .o_tx_bit_valid, .o_tx_symbol, .i_rx_start, .i_rx_bit, .i_rx_bit_valid, .i_rx_bit_is_crc,
        .i_rx_end, .o_rx_byte, .o_rx_byte_valid);
    rfcrc_partner rfcrc_partner_inst (.i_core_clk, .i_slow(slow), .i_bit(o_tx_bit),
        .i_bit_valid(o_tx_bit_valid), .o_ready(tx_bit_ready));
    always #4 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        if (o_tx_ready && i_tx_valid) void'(feed.pop_front());
        i_tx_valid <= feed.size() > 0;
        i_tx_data <= feed.size() ? feed[0] : 8'h00;
        i_tx_last <= feed.size() == 1;
        i_etu_tick <= $urandom_range(5) == 0;
        {env, ext} <= 2'($urandom);
        if (o_rx_byte_valid) rxq.push_back(o_rx_byte);
        nsym += o_tx_symbol;
    end
    task automatic check(string n, logic [31:0] s, logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge i_core_clk) {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
        @(posedge i_core_clk) i_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge i_core_clk) {i_addr, i_rd} <= {a, 1'b1};
        @(posedge i_core_clk) i_rd <= 1'b0;
        @(posedge i_core_clk) rv = o_rdata;
    endtask
    function automatic int crc_of(bit q[$], int p, int k);
        foreach (q[i]) p = ((p ^ q[i]) & 1) ? (p >> 1) ^ poly[k] : p >> 1;
        return p;
    endfunction
    task automatic tx_run(int k, int c);
        bit eb[$];
        logic [31:0] ev = 0, sv = 0;
        int lb = $urandom_range(7), ng = $urandom_range(1), ap = $urandom_range(1), r = 0;
        wr(8'h2e, {3'h0, 1'($urandom), 1'b1, lb[2:0]});
        wr(8'h2c, {1'b0, c[2:0], k[1:0], ng[0], ap[0]});
        for (int i = 0; i < 2; i++) feed.push_back(8'($urandom));
        for (int i = 0; i < ((lb && i > 7) ? 8 + lb : 16); i++) eb.push_back(feed[i / 8][i % 8]);
        if (k < 3) r = crc_of(eb, pt[k][c], k) ^ (ng ? 32'hffff : 0);
        if (ap && k < 3 && pt[k][c] >= 0) for (int i = 0; i < wid[k]; i++) eb.push_back(r[i]);
        rfcrc_partner_inst.q.delete();
        slow <= 1'($urandom);
        wr(8'h42, 8'h01);
        rv = 8'h02;
        for (int i = 0; i < 200 && rv[1]; i++) rd(8'h42);
        foreach (eb[i]) ev[i] = eb[i];
        foreach (rfcrc_partner_inst.q[i]) sv[i] = rfcrc_partner_inst.q[i];
        check("tx bit count", rfcrc_partner_inst.q.size(), eb.size());
        check("tx frame", sv, ev);
        rd(8'h40);
        check("tx done", rv[0], 1'b1);
        wr(8'h40, 8'h07);
    endtask
    task automatic rx_run(int k);
        bit eb[$], cb[$], sb[$];
        logic [7:0] d;
        int en = $urandom_range(1), ng = $urandom_range(1), bad = $urandom_range(1), r;
        int to = k ? $urandom_range(1) : 1; // Unaligned CRC goes to FIFO
        wr(8'h2d, {to[0], 3'h7, k[1:0], ng[0], en[0]});
        for (int i = 0; i < 16; i++) eb.push_back(1'($urandom));
        r = crc_of(eb, pt[k][7], k) ^ (ng ? 32'hffff : 0) ^ bad;
        for (int i = 0; i < wid[k]; i++) cb.push_back(r[i]);
        sb = {eb, cb};
        rxq.delete();
        @(posedge i_core_clk) i_rx_start <= 1'b1;
        foreach (sb[i]) @(posedge i_core_clk) {i_rx_start, i_rx_bit, i_rx_bit_valid, i_rx_bit_is_crc}
            <= {1'b0, sb[i], 1'b1, i > 15};
        @(posedge i_core_clk) {i_rx_bit_valid, i_rx_end} <= 2'b01;
        @(posedge i_core_clk) i_rx_end <= 1'b0;
        rd(8'h40);
        check("rx status", rv[2:1], {en && bad, 1'b1});
        check("irq", o_irq, en && bad);
        if (!to) sb = eb;
        check("rx byte count", rxq.size(), (sb.size() + 7) / 8);
        foreach (rxq[i]) begin
            d = 8'h00;
            for (int b = 0; b < 8 && 8 * i + b < sb.size(); b++) d[b] = sb[8 * i + b];
            check("rx byte", rxq[i], d);
        end
        wr(8'h40, 8'h07);
        @(posedge i_core_clk);
        check("irq cleared", o_irq, 1'b0);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #400us;
        err_count++;
        finish_test();
    end
    initial begin
        void'($urandom(36665));
        up16 = 16'($urandom);
        for (int k = 0; k < 3; k++) pt[k][6] = up16 & ((1 << wid[k]) - 1);
        repeat (5) @(posedge i_core_clk);
        i_rst <= 1'b0;
        rd(8'h2d);
        check("rx cfg reset", rv, 8'h00);
        wr(8'h2c, 8'hff);
        wr(8'h2e, 8'hff);
        wr(8'h10, 8'hff);
        wr(8'h2b, up16[15:8]);
        rd(8'h2c);
        check("tx cfg", rv, 8'h7f);
        rd(8'h2e);
        check("framing", rv, 8'h1f);
        rd(8'h10);
        check("unmapped", rv, 8'h00);
        rd(8'h2b);
        check("trim", rv, up16[15:8]);
        for (int m = 0; m < 4; m++) begin
            wr(8'h2a, m[7:0]);
            repeat (4) @(posedge i_core_clk);
        end
        $display("done registers");
        for (int k = 0; k < 4; k++) for (int c = 0; c < 8; c++) if (c != 4) tx_run(k, c);
        $display("done tx frames");
        rfcrc_partner_inst.q.delete();
        wr(8'h2e, 8'h10);
        nsym = 0;
        wr(8'h42, 8'h01);
        for (int i = 0; i < 300 && nsym == 0; i++) @(posedge i_core_clk);
        repeat (3) @(posedge i_core_clk);
        check("symbol count", nsym, 1);
        check("symbol bits", rfcrc_partner_inst.q.size(), 0);
        $display("done symbol");
        wr(8'h41, 8'h04);
        for (int k = 0; k < 3; k++) repeat (2) rx_run(k);
        $display("done rx frames");
        finish_test();
    end
endmodule // rfcrc_top_bench
